/* event_capture_checker.sv */
// assertion checker for the event capture block, bound to its top module
// assumes one clock and host writes on the same-clock register port
module event_capture_checker (
   input wire       i_clk,
   input wire       i_nrst,
   input wire [6:0] i_reg_addr,
   input wire       i_reg_wr,
   input wire       i_reg_rd,
   input wire [7:0] i_reg_wdata,
   input wire [7:0] o_reg_rdata,
   input wire       o_reg_hit,
   input wire       i_sleep_mode,
   input wire       i_offline_mode,
   input wire       i_serial_frame_end,
   input wire [5:0] i_serial_bit_count,
   input wire       i_serial_illegal_mode,
   input wire       i_serial_locked_write,
   input wire [7:0] o_system_event_status,
   input wire [7:0] o_supply_event_status,
   input wire [7:0] o_transceiver_event_status,
   input wire [7:0] o_wake_pin_event_status
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   wire [31:0] st = {o_wake_pin_event_status, o_transceiver_event_status,
                     o_supply_event_status, o_system_event_status};
   wire        bad = !(i_serial_bit_count inside {6'h10, 6'h18, 6'h20}) ||
                     i_serial_illegal_mode || i_serial_locked_write;
   reg  [31:0] en;
   reg  [8:0]  exp;
   // shadow enables let the gating be judged from the port side
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         en <= 32'h0;
         exp <= 9'h000;
      end else begin
         if (i_reg_wr) case (i_reg_addr)
            7'h04: en[7:0] <= i_reg_wdata & 8'h06;
            7'h1C: en[15:8] <= i_reg_wdata & 8'h07;
            7'h23: en[23:16] <= i_reg_wdata & 8'h13;
            7'h4C: en[31:24] <= i_reg_wdata & 8'h03;
            default: en <= en;
         endcase
         if (i_reg_rd) case (i_reg_addr)
            7'h04: exp <= {1'b1, en[7:0]};
            7'h1C: exp <= {1'b1, en[15:8]};
            7'h23: exp <= {1'b1, en[23:16]};
            7'h4C: exp <= {1'b1, en[31:24]};
            7'h61: exp <= {1'b1, st[7:0]};
            7'h62: exp <= {1'b1, st[15:8]};
            7'h63: exp <= {1'b1, st[23:16]};
            7'h64: exp <= {1'b1, st[31:24]};
            default: exp <= 9'h000;
         endcase
      end
   end
   property p_read; $past(i_reg_rd) |-> {o_reg_hit, o_reg_rdata} == exp; endproperty
   a_read: assert property (p_read) else $error("read answer wrong");
   property p_resv; (st & ~32'h03130706) == 32'h0; endproperty
   a_resv: assert property (p_resv) else $error("reserved status bit set");
   property p_sticky; |($past(st) & ~st) |-> $past(i_reg_wr); endproperty
   a_sticky: assert property (p_sticky) else $error("status fell without write");
   property p_wake; ($rose(st[25]) |-> $past(en[25])) and ($rose(st[24]) |-> $past(en[24]));
   endproperty
   a_wake: assert property (p_wake) else $error("wake flag while disabled");
   property p_trx; ($rose(st[16]) |-> $past(en[16] && i_offline_mode))
      and ($rose(st[17]) |-> $past(en[17] && !i_sleep_mode)); endproperty
   a_trx: assert property (p_trx) else $error("bus flag gating");
   property p_silence; $rose(st[20]) |-> $past(en[20]); endproperty
   a_silence: assert property (p_silence) else $error("silence while disabled");
   property p_serial; i_serial_frame_end && bad && en[1] && !i_sleep_mode |=> st[1]; endproperty
   a_serial: assert property (p_serial) else $error("serial failure missed");
   property p_system; ($rose(st[1]) |-> $past(i_serial_frame_end && en[1] && !i_sleep_mode))
      and ($rose(st[2]) |-> $past(en[2] && !i_sleep_mode)); endproperty
   a_system: assert property (p_system) else $error("system flag gating");
   property p_supply; ($rose(st[8]) |-> $past(en[8] && !i_sleep_mode))
      and ($rose(st[9]) |-> $past(en[9])) and ($rose(st[10]) |-> $past(en[10])); endproperty
   a_supply: assert property (p_supply) else $error("supply flag gating");
endmodule
bind event_capture_status_enable event_capture_checker u_check (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
   .o_reg_hit(o_reg_hit), .i_sleep_mode(i_sleep_mode), .i_offline_mode(i_offline_mode),
   .i_serial_frame_end(i_serial_frame_end), .i_serial_bit_count(i_serial_bit_count),
   .i_serial_illegal_mode(i_serial_illegal_mode),
   .i_serial_locked_write(i_serial_locked_write),
   .o_system_event_status(o_system_event_status),
   .o_supply_event_status(o_supply_event_status),
   .o_transceiver_event_status(o_transceiver_event_status),
   .o_wake_pin_event_status(o_wake_pin_event_status));

/* event_capture_consts.vh */
// register offsets, bit positions, masks and timing for the event capture block
// assumes 7-bit register addresses and 8-bit register data
`ifndef EVENT_CAPTURE_CONSTS_VH
`define EVENT_CAPTURE_CONSTS_VH

`define ADDR_SYSTEM_EVENT_ENABLE      7'h04
`define ADDR_SUPPLY_EVENT_ENABLE      7'h1C
`define ADDR_TRANSCEIVER_EVENT_ENABLE 7'h23
`define ADDR_WAKE_PIN_EVENT_ENABLE    7'h4C
`define ADDR_SYSTEM_EVENT_STATUS      7'h61
`define ADDR_SUPPLY_EVENT_STATUS      7'h62
`define ADDR_TRANSCEIVER_EVENT_STATUS 7'h63
`define ADDR_WAKE_PIN_EVENT_STATUS    7'h64

`define BIT_OVERTEMP      2
`define BIT_SERIAL_FAIL   1
`define BIT_SUPPLY2_OVER  2
`define BIT_SUPPLY2_UNDER 1
`define BIT_SUPPLY1_UNDER 0
`define BIT_BUS_SILENCE   4
`define BIT_BUS_FAILURE   1
`define BIT_BUS_WAKEUP    0
`define BIT_WAKE_RISE     1
`define BIT_WAKE_FALL     0

`define MASK_SYSTEM       8'h06
`define MASK_SUPPLY       8'h07
`define MASK_TRANSCEIVER  8'h13
`define MASK_WAKE_PIN     8'h03

`define RESET_ENABLE      8'h00
`define RESET_STATUS      8'h00

`define CTRL_MODE_FAIL    2'h1
`define SPI_BITS_16       6'h10
`define SPI_BITS_24       6'h18
`define SPI_BITS_32       6'h20

`define CLK_MHZ           100
`define SILENCE_US        1000
`define SILENCE_CYCLES    (`SILENCE_US * `CLK_MHZ)

`endif

/* event_capture_status_enable.v */
// event capture: enable registers gate detected events into sticky status bits
// assumes a simple same-clock register port driven by the serial interface logic;
// analog detector levels and pins are asynchronous and are synchronised here
//
// Function
// - bus failure on supply loss in fail control mode, or on clamped transmit
// - bus wake-up flagged only in offline mode
// - wake input rising edge sets rise flag
// - wake input falling edge sets fall flag
// - system enables: overtemp bit 2, serial bit 1
// - supply enable bit 2 gates overvoltage
// - supply enable bit 1 gates secondary undervoltage
// - supply enable bit 0 gates primary undervoltage
// - transceiver enable bit 4 gates silence
// - transceiver enable bit 1 gates failure
// - transceiver enable bit 0 gates wake-up
// - wake enable bit 1 gates rising edge
// - wake enable bit 0 gates falling edge
// - silence after timeout, only after prior activity
// - primary undervoltage captured, never in sleep
// - serial failure on bad length, mode, lock
// - supply over/under captured at bits 2/1
`include "event_capture_consts.vh"

module event_capture_status_enable #(
   parameter SILENCE_CYCLES = `SILENCE_CYCLES,
   parameter SILENCE_BITS   = 24
) (
   input  wire       i_clk,
   input  wire       i_nrst,
   // register port
   input  wire [6:0] i_reg_addr,
   input  wire       i_reg_wr,
   input  wire       i_reg_rd,
   input  wire [7:0] i_reg_wdata,
   output reg  [7:0] o_reg_rdata,
   output reg        o_reg_hit,
   // device mode, same clock
   input  wire       i_sleep_mode,
   input  wire       i_offline_mode,
   input  wire [1:0] i_transceiver_control_mode,
   // serial frame checks, same clock
   input  wire       i_serial_frame_end,
   input  wire [5:0] i_serial_bit_count,
   input  wire       i_serial_illegal_mode,
   input  wire       i_serial_locked_write,
   // asynchronous detector levels and pins
   input  wire       i_overtemp_warning,
   input  wire       i_primary_regulator_under,
   input  wire       i_secondary_regulator_over,
   input  wire       i_secondary_regulator_under,
   input  wire       i_bus_supply_under,
   input  wire       i_tx_clamped,
   input  wire       i_bus_wakeup,
   input  wire       i_bus_rx,
   input  wire       i_wake,
   // status levels for the rest of the chip
   output wire [7:0] o_system_event_status,
   output wire [7:0] o_supply_event_status,
   output wire [7:0] o_transceiver_event_status,
   output wire [7:0] o_wake_pin_event_status
);

   // lane order of the synchroniser
   localparam L_OTW  = 0;
   localparam L_PUV  = 1;
   localparam L_SOV  = 2;
   localparam L_SUV  = 3;
   localparam L_CUV  = 4;
   localparam L_TXC  = 5;
   localparam L_CWK  = 6;
   localparam L_RX   = 7;
   localparam L_WAKE = 8;
   localparam NSYNC  = 9;

   // enable registers
   reg  [7:0] system_event_enable;
   reg  [7:0] supply_event_enable;
   reg  [7:0] transceiver_event_enable;
   reg  [7:0] wake_pin_event_enable;

   // status registers
   reg  [7:0] system_event_status;
   reg  [7:0] supply_event_status;
   reg  [7:0] transceiver_event_status;
   reg  [7:0] wake_pin_event_status;

   // synchronised views
   wire [NSYNC-1:0] sync_level;
   wire [NSYNC-1:0] sync_rise;
   wire [NSYNC-1:0] sync_fall;

   // raw events before gating
   wire       overtemp_evt;
   wire       serial_fail_evt;
   wire       primary_under_evt;
   wire       secondary_over_evt;
   wire       secondary_under_evt;
   wire       bus_failure_evt;
   wire       bus_wakeup_evt;
   wire       bus_silence_evt;
   wire       wake_rise_evt;
   wire       wake_fall_evt;

   wire       bus_failure_cond;
   reg        bus_failure_last;
   wire       bus_activity;

   // event vectors laid out as the status registers
   reg  [7:0] system_events;
   reg  [7:0] supply_events;
   reg  [7:0] transceiver_events;
   reg  [7:0] wake_pin_events;

   // write decode
   wire       wr_system_en;
   wire       wr_supply_en;
   wire       wr_transceiver_en;
   wire       wr_wake_en;
   wire       wr_system_st;
   wire       wr_supply_st;
   wire       wr_transceiver_st;
   wire       wr_wake_st;

   reg  [7:0] next_rdata;
   reg        next_hit;

   // legal serial frame lengths
   function length_ok;
      input [5:0] bits;
      begin
         length_ok = (bits == `SPI_BITS_16) ||
                     (bits == `SPI_BITS_24) ||
                     (bits == `SPI_BITS_32);
      end
   endfunction

   // sticky status update: set wins over a write-one clear in the same cycle
   function [7:0] sticky;
      input [7:0] cur;
      input [7:0] evt;
      input [7:0] en;
      input [7:0] mask;
      input       wr;
      input [7:0] wdata;
      reg   [7:0] clr;
      begin
         clr    = wr ? wdata : 8'h00;
         sticky = ((cur & ~clr) | (evt & en)) & mask;
      end
   endfunction

   sync_edge #(
      .W (NSYNC)
   ) u_sync (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_async ({i_wake,
                 i_bus_rx,
                 i_bus_wakeup,
                 i_tx_clamped,
                 i_bus_supply_under,
                 i_secondary_regulator_under,
                 i_secondary_regulator_over,
                 i_primary_regulator_under,
                 i_overtemp_warning}),
      .o_level (sync_level),
      .o_rise  (sync_rise),
      .o_fall  (sync_fall)
   );

   // detectors are level outputs; the onset of a condition is the event
   assign overtemp_evt = sync_rise[L_OTW] & ~i_sleep_mode;

   assign serial_fail_evt = i_serial_frame_end & ~i_sleep_mode &
                            (~length_ok(i_serial_bit_count) |
                             i_serial_illegal_mode |
                             i_serial_locked_write);

   // regulator is off in sleep, so its comparator output is meaningless there
   assign primary_under_evt = sync_rise[L_PUV] & ~i_sleep_mode;

   assign secondary_over_evt  = sync_rise[L_SOV];
   assign secondary_under_evt = sync_rise[L_SUV];

   // failure condition is a combination; edge-detect it after synchronising the parts
   assign bus_failure_cond =
      ((i_transceiver_control_mode == `CTRL_MODE_FAIL) & sync_level[L_CUV]) |
      sync_level[L_TXC];

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         bus_failure_last <= 1'b0;
      end else begin
         bus_failure_last <= bus_failure_cond;
      end
   end

   assign bus_failure_evt = bus_failure_cond & ~bus_failure_last &
                            ~i_sleep_mode;

   assign bus_wakeup_evt = sync_rise[L_CWK] & i_offline_mode;

   assign wake_rise_evt = sync_rise[L_WAKE];
   assign wake_fall_evt = sync_fall[L_WAKE];

   // any receive edge counts as bus activity
   assign bus_activity = sync_rise[L_RX] | sync_fall[L_RX];

   silence_timer #(
      .LIMIT (SILENCE_CYCLES),
      .CNT_W (SILENCE_BITS)
   ) u_silence (
      .i_clk      (i_clk),
      .i_nrst     (i_nrst),
      .i_enable   (transceiver_event_enable[`BIT_BUS_SILENCE]),
      .i_activity (bus_activity),
      .o_timeout  (bus_silence_evt)
   );

   always @* begin
      system_events      = 8'h00;
      supply_events      = 8'h00;
      transceiver_events = 8'h00;
      wake_pin_events    = 8'h00;
      system_events[`BIT_OVERTEMP]         = overtemp_evt;
      system_events[`BIT_SERIAL_FAIL]      = serial_fail_evt;
      supply_events[`BIT_SUPPLY2_OVER]     = secondary_over_evt;
      supply_events[`BIT_SUPPLY2_UNDER]    = secondary_under_evt;
      supply_events[`BIT_SUPPLY1_UNDER]    = primary_under_evt;
      transceiver_events[`BIT_BUS_SILENCE] = bus_silence_evt;
      transceiver_events[`BIT_BUS_FAILURE] = bus_failure_evt;
      transceiver_events[`BIT_BUS_WAKEUP]  = bus_wakeup_evt;
      wake_pin_events[`BIT_WAKE_RISE]      = wake_rise_evt;
      wake_pin_events[`BIT_WAKE_FALL]      = wake_fall_evt;
   end

   assign wr_system_en      = i_reg_wr & (i_reg_addr == `ADDR_SYSTEM_EVENT_ENABLE);
   assign wr_supply_en      = i_reg_wr & (i_reg_addr == `ADDR_SUPPLY_EVENT_ENABLE);
   assign wr_transceiver_en = i_reg_wr & (i_reg_addr == `ADDR_TRANSCEIVER_EVENT_ENABLE);
   assign wr_wake_en        = i_reg_wr & (i_reg_addr == `ADDR_WAKE_PIN_EVENT_ENABLE);
   assign wr_system_st      = i_reg_wr & (i_reg_addr == `ADDR_SYSTEM_EVENT_STATUS);
   assign wr_supply_st      = i_reg_wr & (i_reg_addr == `ADDR_SUPPLY_EVENT_STATUS);
   assign wr_transceiver_st = i_reg_wr & (i_reg_addr == `ADDR_TRANSCEIVER_EVENT_STATUS);
   assign wr_wake_st        = i_reg_wr & (i_reg_addr == `ADDR_WAKE_PIN_EVENT_STATUS);

   // enable registers: only documented bits are stored
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         system_event_enable      <= `RESET_ENABLE;
         supply_event_enable      <= `RESET_ENABLE;
         transceiver_event_enable <= `RESET_ENABLE;
         wake_pin_event_enable    <= `RESET_ENABLE;
      end else begin
         if (wr_system_en) begin
            system_event_enable <= i_reg_wdata & `MASK_SYSTEM;
         end
         if (wr_supply_en) begin
            supply_event_enable <= i_reg_wdata & `MASK_SUPPLY;
         end
         if (wr_transceiver_en) begin
            transceiver_event_enable <= i_reg_wdata & `MASK_TRANSCEIVER;
         end
         if (wr_wake_en) begin
            wake_pin_event_enable <= i_reg_wdata & `MASK_WAKE_PIN;
         end
      end
   end

   // status registers: each bit latches only with its enable set
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         system_event_status      <= `RESET_STATUS;
         supply_event_status      <= `RESET_STATUS;
         transceiver_event_status <= `RESET_STATUS;
         wake_pin_event_status    <= `RESET_STATUS;
      end else begin
         system_event_status <= sticky(system_event_status,
                                       system_events,
                                       system_event_enable,
                                       `MASK_SYSTEM,
                                       wr_system_st,
                                       i_reg_wdata);
         supply_event_status <= sticky(supply_event_status,
                                       supply_events,
                                       supply_event_enable,
                                       `MASK_SUPPLY,
                                       wr_supply_st,
                                       i_reg_wdata);
         transceiver_event_status <= sticky(transceiver_event_status,
                                            transceiver_events,
                                            transceiver_event_enable,
                                            `MASK_TRANSCEIVER,
                                            wr_transceiver_st,
                                            i_reg_wdata);
         wake_pin_event_status <= sticky(wake_pin_event_status,
                                         wake_pin_events,
                                         wake_pin_event_enable,
                                         `MASK_WAKE_PIN,
                                         wr_wake_st,
                                         i_reg_wdata);
      end
   end

   // read mux; unmapped addresses answer zero with no hit
   always @* begin
      next_rdata = 8'h00;
      next_hit   = 1'b1;
      case (i_reg_addr)
         `ADDR_SYSTEM_EVENT_ENABLE: begin
            next_rdata = system_event_enable;
         end
         `ADDR_SUPPLY_EVENT_ENABLE: begin
            next_rdata = supply_event_enable;
         end
         `ADDR_TRANSCEIVER_EVENT_ENABLE: begin
            next_rdata = transceiver_event_enable;
         end
         `ADDR_WAKE_PIN_EVENT_ENABLE: begin
            next_rdata = wake_pin_event_enable;
         end
         `ADDR_SYSTEM_EVENT_STATUS: begin
            next_rdata = system_event_status;
         end
         `ADDR_SUPPLY_EVENT_STATUS: begin
            next_rdata = supply_event_status;
         end
         `ADDR_TRANSCEIVER_EVENT_STATUS: begin
            next_rdata = transceiver_event_status;
         end
         `ADDR_WAKE_PIN_EVENT_STATUS: begin
            next_rdata = wake_pin_event_status;
         end
         default: begin
            next_hit = 1'b0;
         end
      endcase
   end

   // read data held until the next read so a slow shifter can pick it up
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_reg_rdata <= 8'h00;
         o_reg_hit   <= 1'b0;
      end else if (i_reg_rd) begin
         o_reg_rdata <= next_rdata;
         o_reg_hit   <= next_hit;
      end
   end

   assign o_system_event_status      = system_event_status;
   assign o_supply_event_status      = supply_event_status;
   assign o_transceiver_event_status = transceiver_event_status;
   assign o_wake_pin_event_status    = wake_pin_event_status;

endmodule

/* event_capture_status_enable_bench.sv */
// self-checking bench for the event capture block
// assumes the source model plays the analog detectors and pins
`include "event_capture_consts.vh"
module event_capture_status_enable_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam [6:0]  ESY = `ADDR_SYSTEM_EVENT_ENABLE;
   localparam [6:0]  ESU = `ADDR_SUPPLY_EVENT_ENABLE;
   localparam [6:0]  ETR = `ADDR_TRANSCEIVER_EVENT_ENABLE;
   localparam [6:0]  EWK = `ADDR_WAKE_PIN_EVENT_ENABLE;
   localparam [6:0]  SSY = `ADDR_SYSTEM_EVENT_STATUS;
   localparam [6:0]  SSU = `ADDR_SUPPLY_EVENT_STATUS;
   localparam [6:0]  STR = `ADDR_TRANSCEIVER_EVENT_STATUS;
   localparam [6:0]  SWK = `ADDR_WAKE_PIN_EVENT_STATUS;
   localparam [62:0] ADDRS = {7'h7F, SWK, STR, SSU, SSY, EWK, ETR, ESU, ESY};
   localparam [31:0] MASKS = {`MASK_WAKE_PIN, `MASK_TRANSCEIVER, `MASK_SUPPLY, `MASK_SYSTEM};
   reg        i_clk = 1'b0;
   reg        i_nrst = 1'b0;
   reg  [6:0] i_reg_addr = 7'h00;
   reg        i_reg_wr = 1'b0;
   reg        i_reg_rd = 1'b0;
   reg  [7:0] i_reg_wdata = 8'h00;
   reg        i_sleep_mode = 1'b0;
   reg        i_offline_mode = 1'b0;
   reg  [1:0] i_cmode = 2'h0;
   reg        i_frame_end = 1'b0;
   reg  [5:0] i_bit_count = 6'h00;
   reg        i_illegal = 1'b0;
   reg        i_locked = 1'b0;
   reg  [8:0] want = 9'h000;
   wire [8:0] lv;
   wire [7:0] o_reg_rdata;
   wire       o_reg_hit;
   integer    n_mismatch = 0;
   integer    num_checks = 0;
   integer    k;
   always #5 i_clk = ~i_clk;
   event_source_model model (.i_want(want), .o_level(lv));
   event_capture_status_enable #(.SILENCE_CYCLES(20), .SILENCE_BITS(24)) DUT (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .o_reg_hit(o_reg_hit), .i_sleep_mode(i_sleep_mode), .i_offline_mode(i_offline_mode),
      .i_transceiver_control_mode(i_cmode), .i_serial_frame_end(i_frame_end),
      .i_serial_bit_count(i_bit_count), .i_serial_illegal_mode(i_illegal),
      .i_serial_locked_write(i_locked), .i_overtemp_warning(lv[0]),
      .i_primary_regulator_under(lv[1]), .i_secondary_regulator_over(lv[2]),
      .i_secondary_regulator_under(lv[3]), .i_bus_supply_under(lv[4]),
      .i_tx_clamped(lv[5]), .i_bus_wakeup(lv[6]), .i_bus_rx(lv[7]), .i_wake(lv[8]),
      .o_system_event_status(), .o_supply_event_status(),
      .o_transceiver_event_status(), .o_wake_pin_event_status());
   task chk(input [7:0] seen, input [7:0] e);
      begin
         num_checks = num_checks + 1;
         if (seen !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, e);
         end
      end
   endtask
   task wr(input [6:0] a, input [7:0] d);
      begin
         @(posedge i_clk);
         i_reg_addr <= a;
         i_reg_wdata <= d;
         i_reg_wr <= 1'b1;
         @(posedge i_clk);
         i_reg_wr <= 1'b0;
      end
   endtask
   task rd(input [6:0] a, input [7:0] e);
      begin
         @(posedge i_clk);
         i_reg_addr <= a;
         i_reg_rd <= 1'b1;
         @(posedge i_clk);
         i_reg_rd <= 1'b0;
         #1 chk(o_reg_rdata, e);
      end
   endtask
   // eight cycles cover the synchroniser and edge flop with margin
   task lvl(input [8:0] v);
      begin
         @(posedge i_clk);
         want <= v;
         repeat (8) @(posedge i_clk);
      end
   endtask
   task mode(input s, input o, input [1:0] c);
      begin
         @(posedge i_clk);
         i_sleep_mode <= s;
         i_offline_mode <= o;
         i_cmode <= c;
      end
   endtask
   task frame(input [5:0] c, input il, input lk);
      begin
         @(posedge i_clk);
         i_bit_count <= c;
         i_illegal <= il;
         i_locked <= lk;
         i_frame_end <= 1'b1;
         @(posedge i_clk);
         i_frame_end <= 1'b0;
      end
   endtask
   task fin(input [63:0] t);
      $display("test %0s done", t);
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_mismatch);
         if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      #400000;
      n_mismatch = n_mismatch + 1;
      wrap_up;
   end
   initial begin
      repeat (20) @(posedge i_clk);
      i_nrst <= 1'b1;
      for (k = 0; k < 9; k = k + 1) begin
         rd(ADDRS[k*7 +: 7], 8'h00);
         chk({7'h00, o_reg_hit}, {7'h00, k < 8});
      end
      for (k = 0; k < 4; k = k + 1) begin
         wr(ADDRS[k*7 +: 7], 8'hFF);
         rd(ADDRS[k*7 +: 7], MASKS[k*8 +: 8]);
         wr(ADDRS[k*7 +: 7], 8'h00);
      end
      fin("regs");
      lvl(9'h17F);
      frame(6'h11, 1'b0, 1'b0);
      for (k = 4; k < 8; k = k + 1) rd(ADDRS[k*7 +: 7], 8'h00);
      lvl(9'h000);
      fin("disabled");
      wr(EWK, 8'h03);
      lvl(9'h100);
      rd(SWK, 8'h02);
      lvl(9'h000);
      rd(SWK, 8'h03);
      wr(SWK, 8'h02);
      rd(SWK, 8'h01);
      wr(EWK, 8'h01);
      lvl(9'h100);
      rd(SWK, 8'h01);
      wr(SWK, 8'hFF);
      lvl(9'h000);
      rd(SWK, 8'h01);
      wr(SWK, 8'h01);
      rd(SWK, 8'h00);
      fin("wake");
      wr(ESY, 8'h06);
      for (k = 0; k < 3; k = k + 1) frame(6'h10 + {k[1:0], 3'h0}, 1'b0, 1'b0);
      rd(SSY, 8'h00);
      frame(6'h11, 1'b0, 1'b0);
      rd(SSY, 8'h02);
      wr(SSY, 8'h02);
      frame(6'h10, 1'b1, 1'b0);
      rd(SSY, 8'h02);
      wr(SSY, 8'h02);
      frame(6'h20, 1'b0, 1'b1);
      rd(SSY, 8'h02);
      wr(SSY, 8'h02);
      mode(1'b1, 1'b0, 2'h0);
      frame(6'h0F, 1'b0, 1'b0);
      lvl(9'h001);
      rd(SSY, 8'h00);
      mode(1'b0, 1'b0, 2'h0);
      lvl(9'h000);
      lvl(9'h001);
      rd(SSY, 8'h04);
      wr(SSY, 8'hFF);
      lvl(9'h000);
      fin("system");
      wr(ESU, 8'h07);
      lvl(9'h00E);
      rd(SSU, 8'h07);
      wr(SSU, 8'hFF);
      lvl(9'h000);
      wr(ESU, 8'h01);
      lvl(9'h00C);
      rd(SSU, 8'h00);
      lvl(9'h000);
      wr(ESU, 8'h07);
      mode(1'b1, 1'b0, 2'h0);
      lvl(9'h00E);
      rd(SSU, 8'h06);
      mode(1'b0, 1'b0, 2'h0);
      lvl(9'h000);
      fin("supply");
      wr(ETR, 8'h13);
      lvl(9'h040);
      repeat (40) @(posedge i_clk);
      rd(STR, 8'h00);
      lvl(9'h000);
      mode(1'b0, 1'b1, 2'h1);
      lvl(9'h040);
      rd(STR, 8'h01);
      lvl(9'h050);
      rd(STR, 8'h03);
      wr(STR, 8'hFF);
      lvl(9'h040);
      mode(1'b0, 1'b1, 2'h0);
      lvl(9'h050);
      rd(STR, 8'h00);
      lvl(9'h060);
      rd(STR, 8'h02);
      wr(STR, 8'hFF);
      lvl(9'h040);
      mode(1'b1, 1'b1, 2'h0);
      lvl(9'h060);
      rd(STR, 8'h00);
      mode(1'b0, 1'b1, 2'h0);
      lvl(9'h000);
      wr(ETR, 8'h11);
      lvl(9'h020);
      rd(STR, 8'h00);
      lvl(9'h080);
      repeat (40) @(posedge i_clk);
      rd(STR, 8'h10);
      wr(STR, 8'h10);
      repeat (40) @(posedge i_clk);
      rd(STR, 8'h00);
      wr(ETR, 8'h01);
      lvl(9'h000);
      repeat (40) @(posedge i_clk);
      rd(STR, 8'h00);
      fin("bus");
      wrap_up;
   end
endmodule

/* event_source_model.sv */
// far-side model of the analog detectors and pins feeding the block
// assumes the bench asks for level changes; they land off the clock edge
module event_source_model (
   input  wire [8:0] i_want,
   output reg  [8:0] o_level
);
   timeunit 1ns;
   timeprecision 100ps;
   initial o_level = 9'h000;
   // delay keeps edges unrelated to the sampling edge, as real detectors are
   always @(i_want) o_level <= #3.7 i_want;
endmodule

/* silence_timer.v */
// bus silence timer: pulses once when no activity for LIMIT cycles after activity
// assumes i_activity is a same-clock pulse
module silence_timer #(
   parameter LIMIT = 100000,
   parameter CNT_W = 24
) (
   input  wire i_clk,
   input  wire i_nrst,
   input  wire i_enable,
   input  wire i_activity,
   output reg  o_timeout
);
   reg [CNT_W-1:0] count;
   reg          was_active;

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         count      <= {CNT_W{1'b0}};
         was_active <= 1'b0;
         o_timeout  <= 1'b0;
      end else begin
         o_timeout <= 1'b0;
         if (!i_enable) begin
            // disabled: forget history so no stale silence fires on re-enable
            count      <= {CNT_W{1'b0}};
            was_active <= 1'b0;
         end else if (i_activity) begin
            count      <= {CNT_W{1'b0}};
            was_active <= 1'b1;
         end else if (was_active) begin
            if (count == LIMIT[CNT_W-1:0] - 1'b1) begin
               o_timeout  <= 1'b1;
               was_active <= 1'b0;
               count      <= {CNT_W{1'b0}};
            end else begin
               count <= count + 1'b1;
            end
         end
      end
   end
endmodule

/* sync_edge.v */
// two-flop synchroniser with edge detection, one lane per input bit
// assumes inputs are asynchronous to i_clk
module sync_edge #(
   parameter W = 1
) (
   input  wire         i_clk,
   input  wire         i_nrst,
   input  wire [W-1:0] i_async,
   output wire [W-1:0] o_level,
   output wire [W-1:0] o_rise,
   output wire [W-1:0] o_fall
);
   reg [W-1:0] meta;
   reg [W-1:0] stable;
   reg [W-1:0] last;

   // first stage feeds only the second stage
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta   <= {W{1'b0}};
         stable <= {W{1'b0}};
         last   <= {W{1'b0}};
      end else begin
         meta   <= i_async;
         stable <= meta;
         last   <= stable;
      end
   end

   assign o_level = stable;
   assign o_rise  = stable & ~last;
   assign o_fall  = ~stable & last;
endmodule
